// ### inc/dom_pkg.sv
// Purpose: Shared constants and carriers for the digital output mux
// Assumes: Parameter indices are 16-bit object-dictionary indices
// Notes:   Selector bit 7 chooses normally-closed polarity
package dom_pkg;

	// ==========================================================
	// Parameter and object indices
	// ==========================================================
	localparam logic [15:0] IDX_OUT1_SEL   = 16'h2410;
	localparam logic [15:0] IDX_OUT2_SEL   = 16'h2411;
	localparam logic [15:0] IDX_OUT3_SEL   = 16'h2412;
	localparam logic [15:0] IDX_MASTER_DO  = 16'h60FE;
	localparam logic [7:0]  SUB_MASTER_DO  = 8'h01;
	localparam int          MASTER_BIT_LO  = 16;
	localparam int          NUM_OUT        = 3;

	// ==========================================================
	// Selector field layout and values
	// ==========================================================
	localparam int          SEL_POL_BIT    = 7;
	localparam logic [7:0]  SEL_RESET      = 8'h00;
	localparam logic [6:0]  SEL_MASTER     = 7'h00;
	localparam logic [7:0]  DEF_OUT1_SEL   = 8'h02;
	localparam logic [7:0]  DEF_OUT2_SEL   = 8'h01;
	localparam logic [7:0]  DEF_OUT3_SEL   = 8'h03;

	// Function codes in normally-open form
	localparam logic [6:0]  FN_ALARM       = 7'h01;
	localparam logic [6:0]  FN_READY       = 7'h02;
	localparam logic [6:0]  FN_BRAKE       = 7'h03;
	localparam logic [6:0]  FN_INPOS       = 7'h04;
	localparam logic [6:0]  FN_ATSPEED     = 7'h05;
	localparam logic [6:0]  FN_TORQUE      = 7'h06;
	localparam logic [6:0]  FN_ZEROSPD     = 7'h07;
	localparam logic [6:0]  FN_VMATCH      = 7'h08;
	localparam logic [6:0]  FN_PCMD        = 7'h0B;
	localparam logic [6:0]  FN_VLIMIT      = 7'h0D;
	localparam logic [6:0]  FN_VCMD        = 7'h0F;
	localparam logic [6:0]  FN_STATE       = 7'h12;
	localparam logic [6:0]  FN_COMPARE     = 7'h14;
	localparam logic [6:0]  FN_HOMED       = 7'h22;

	// ==========================================================
	// Carriers
	// ==========================================================
	// Internal drive status functions, all active high
	typedef struct packed {
		logic fault_flag;
		logic servo_ready;
		logic brake_release_flag;
		logic in_position_flag;
		logic speed_reached_flag;
		logic torque_limited_flag;
		logic zero_speed_flag;
		logic velocity_match_flag;
		logic position_cmd_active;
		logic velocity_limit_active;
		logic velocity_cmd_active;
		logic drive_state_flag;
		logic position_compare_output;
		logic homing_done;
	} dom_status_s;

	// Divided encoder phases, single ended, active high
	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic phase_z;
	} dom_enc_s;

	// Differential encoder pair outputs
	typedef struct packed {
		logic a_p;
		logic a_n;
		logic b_p;
		logic b_n;
		logic z_p;
		logic z_n;
	} dom_diff_s;

endpackage

// ### logic/dom_chan.sv
// Purpose: Decode one output selector into a pin level
// Assumes: Pure combinational, registered by the caller
// Notes:   Undefined codes report not defined and give the idle level
`timescale 1ns/1ps
module dom_chan
(
	input  wire logic [7:0]          i_sel,      // Selector code
	input  wire dom_pkg::dom_status_s i_status,  // Status functions
	input  wire logic                i_master,   // Master-written bit
	output logic                     o_level,    // Next pin level
	output logic                     o_defined,  // Code is a function
	output logic [6:0]               o_func      // Function part
);

	// ==========================================================
	// Function select
	// ==========================================================
	logic       fn_active;  // Selected function asserted
	logic       fn_known;   // Code is in the table
	logic       nc_form;    // Normally-closed polarity
	logic [6:0] fn_code;    // Code without polarity bit

	assign nc_form = i_sel[dom_pkg::SEL_POL_BIT];
	assign fn_code = i_sel[6:0];
	assign o_func  = fn_code;

	// Table lookup of the selected status function
	always_comb
	begin
		fn_active = 1'b0;
		fn_known  = 1'b1;
		case (fn_code)
			dom_pkg::FN_ALARM:   fn_active = i_status.fault_flag;
			dom_pkg::FN_READY:   fn_active = i_status.servo_ready;
			dom_pkg::FN_BRAKE:   fn_active = i_status.brake_release_flag;
			dom_pkg::FN_INPOS:   fn_active = i_status.in_position_flag;
			dom_pkg::FN_ATSPEED: fn_active = i_status.speed_reached_flag;
			dom_pkg::FN_TORQUE:  fn_active = i_status.torque_limited_flag;
			dom_pkg::FN_ZEROSPD: fn_active = i_status.zero_speed_flag;
			dom_pkg::FN_VMATCH:  fn_active = i_status.velocity_match_flag;
			dom_pkg::FN_PCMD:    fn_active = i_status.position_cmd_active;
			dom_pkg::FN_VLIMIT:  fn_active = i_status.velocity_limit_active;
			dom_pkg::FN_VCMD:    fn_active = i_status.velocity_cmd_active;
			dom_pkg::FN_STATE:   fn_active = i_status.drive_state_flag;
			dom_pkg::FN_COMPARE: fn_active = i_status.position_compare_output;
			dom_pkg::FN_HOMED:   fn_active = i_status.homing_done;
			default:             fn_known  = 1'b0;
		endcase
	end

	// Polarity and master control
	always_comb
	begin
		o_defined = 1'b0;
		if (i_sel == dom_pkg::SEL_RESET)
		begin
			// Master drives the pin
			o_level = i_master;
		end
		else if (fn_known && (fn_code != dom_pkg::SEL_MASTER))
		begin
			o_defined = 1'b1;
			// NO form drives low when active, NC form high
			o_level = nc_form ? fn_active : ~fn_active;
		end
		else
		begin
			// Unknown code: idle level of the chosen polarity
			o_level = ~nc_form;
		end
	end

endmodule

// ### logic/dom_top.sv
// Purpose: Route drive status functions onto three digital outputs
// Assumes: Status, encoder and parameter ports are on i_clk
// Notes:   Selectors reset to zero, so pins start under master control
`timescale 1ns/1ps

module dom_top
(
	input  wire logic                 i_clk,          // 100 MHz clock
	input  wire logic                 i_nrst,         // Async reset
	input  wire logic                 i_par_wr,       // Parameter write
	input  wire logic                 i_par_rd,       // Parameter read
	input  wire logic [15:0]          i_par_index,    // Parameter index
	input  wire logic [7:0]           i_par_sub,      // Sub-index
	input  wire logic [31:0]          i_par_wdata,    // Write data
	input  wire logic                 i_load_defaults,// Factory load
	input  wire dom_pkg::dom_status_s i_status,       // Status functions
	input  wire dom_pkg::dom_enc_s    i_enc,          // Divided encoder
	output logic [31:0]               o_par_rdata,    // Read data
	output logic                      o_par_ack,      // Access done
	output logic                      o_first_digital_output,
	output logic                      o_second_digital_output,
	output logic                      o_third_digital_output,
	output dom_pkg::dom_diff_s        o_enc_diff,     // Encoder pairs
	output logic                      o_index_open_collector_out,
	output logic                      o_index_open_collector_out_oe_n,
	output logic                      o_duplicate_assignment_error
);

	// ==========================================================
	// Reset synchroniser
	// ==========================================================
	logic rst_meta_n;  // First stage, read only by second
	logic rst_n;       // Released reset used by the block

	// Assert at once, release after two edges
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// ==========================================================
	// Selector registers and master bits
	// ==========================================================
	logic [7:0] sel [dom_pkg::NUM_OUT];  // Output selectors
	logic [2:0] master_do;               // Master-written levels
	logic       wr_sel1;                 // Write hits selector 1
	logic       wr_sel2;                 // Write hits selector 2
	logic       wr_sel3;                 // Write hits selector 3
	logic       wr_master;               // Write hits master object

	// Index decode
	always_comb
	begin
		wr_sel1   = 1'b0;
		wr_sel2   = 1'b0;
		wr_sel3   = 1'b0;
		wr_master = 1'b0;
		if (i_par_index == dom_pkg::IDX_OUT1_SEL)
		begin
			// First output's selector
			wr_sel1 = i_par_wr;
		end
		else if (i_par_index == dom_pkg::IDX_OUT2_SEL)
		begin
			// Second output's selector
			wr_sel2 = i_par_wr;
		end
		else if (i_par_index == dom_pkg::IDX_OUT3_SEL)
		begin
			// Third output's selector
			wr_sel3 = i_par_wr;
		end
		else if ((i_par_index == dom_pkg::IDX_MASTER_DO) &&
			(i_par_sub == dom_pkg::SUB_MASTER_DO))
		begin
			// Master object, only its first sub-index
			wr_master = i_par_wr;
		end
	end

	// Selector storage, any value 00h to FFh accepted
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel[0] <= dom_pkg::SEL_RESET;
			sel[1] <= dom_pkg::SEL_RESET;
			sel[2] <= dom_pkg::SEL_RESET;
		end
		else if (i_load_defaults)
		begin
			// Factory set, all normally-open
			sel[0] <= dom_pkg::DEF_OUT1_SEL;
			sel[1] <= dom_pkg::DEF_OUT2_SEL;
			sel[2] <= dom_pkg::DEF_OUT3_SEL;
		end
		else
		begin
			// New code steers the pin from the next edge
			if (wr_sel1)
			begin
				sel[0] <= i_par_wdata[7:0];
			end
			if (wr_sel2)
			begin
				sel[1] <= i_par_wdata[7:0];
			end
			if (wr_sel3)
			begin
				sel[2] <= i_par_wdata[7:0];
			end
		end
	end

	// Master output bits from the digital-output object
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Master-controlled pins start low once released
			master_do <= 3'h0;
		end
		else if (wr_master)
		begin
			master_do <= i_par_wdata[dom_pkg::MASTER_BIT_LO +: 3];
		end
	end

	// ==========================================================
	// Read and acknowledge
	// ==========================================================
	logic [31:0] next_rdata;  // Read mux result

	// Read mux; unmapped indices read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (i_par_index == dom_pkg::IDX_OUT1_SEL)
		begin
			// First selector, zero extended
			next_rdata = {24'h00_0000, sel[0]};
		end
		else if (i_par_index == dom_pkg::IDX_OUT2_SEL)
		begin
			// Second selector, zero extended
			next_rdata = {24'h00_0000, sel[1]};
		end
		else if (i_par_index == dom_pkg::IDX_OUT3_SEL)
		begin
			// Third selector, zero extended
			next_rdata = {24'h00_0000, sel[2]};
		end
		else if ((i_par_index == dom_pkg::IDX_MASTER_DO) &&
			(i_par_sub == dom_pkg::SUB_MASTER_DO))
		begin
			// Master levels back in their object bits
			next_rdata = {13'h0000, master_do, 16'h0000};
		end
	end

	// Registered read data, held until the next read
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_par_rdata <= 32'h0000_0000;
		end
		else if (i_par_rd)
		begin
			// Captured on the read strobe only
			o_par_rdata <= next_rdata;
		end
	end

	// One-cycle acknowledge for each access
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_par_ack <= 1'b0;
		end
		else
		begin
			o_par_ack <= i_par_rd | i_par_wr;
		end
	end

	// ==========================================================
	// Output channels
	// ==========================================================
	logic [2:0] next_level;  // Decoded pin levels
	logic [2:0] defined;     // Channel carries a function
	logic [6:0] func [dom_pkg::NUM_OUT];  // Function codes

	// One decoder per output; no mode input, so all modes apply
	for (genvar g = 0; g < dom_pkg::NUM_OUT; g++)
	begin : g_chan
		dom_chan i_dom_chan
		(
			.i_sel     (sel[g]),
			.i_status  (i_status),
			.i_master  (master_do[g]),
			.o_level   (next_level[g]),
			.o_defined (defined[g]),
			.o_func    (func[g])
		);
	end

	// Pin registers; high is the idle level of the open form
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Idle level of the open form while held
			o_first_digital_output  <= 1'b1;
			o_second_digital_output <= 1'b1;
			o_third_digital_output  <= 1'b1;
		end
		else
		begin
			o_first_digital_output  <= next_level[0];
			o_second_digital_output <= next_level[1];
			o_third_digital_output  <= next_level[2];
		end
	end

	// ==========================================================
	// Duplicate assignment check
	// ==========================================================
	logic next_dup;  // Same function on two channels

	// Compare function parts of defined channels pairwise
	always_comb
	begin
		next_dup = (defined[0] && defined[1] && (func[0] == func[1])) ||
			(defined[0] && defined[2] && (func[0] == func[2])) ||
			(defined[1] && defined[2] && (func[1] == func[2]));
	end

	// Error level, follows the current configuration
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_duplicate_assignment_error <= 1'b0;
		end
		else
		begin
			o_duplicate_assignment_error <= next_dup;
		end
	end

	// ==========================================================
	// Divided encoder outputs
	// ==========================================================
	// Differential pairs and the open-collector index
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_enc_diff                      <= 6'b01_0101;
			o_index_open_collector_out      <= 1'b0;
			o_index_open_collector_out_oe_n <= 1'b1;
		end
		else
		begin
			o_enc_diff.a_p <= i_enc.phase_a;
			o_enc_diff.a_n <= ~i_enc.phase_a;
			o_enc_diff.b_p <= i_enc.phase_b;
			o_enc_diff.b_n <= ~i_enc.phase_b;
			o_enc_diff.z_p <= i_enc.phase_z;
			o_enc_diff.z_n <= ~i_enc.phase_z;
			// Transistor pulls low during the index pulse
			o_index_open_collector_out      <= 1'b0;
			o_index_open_collector_out_oe_n <= ~i_enc.phase_z;
		end
	end

endmodule

// ### test/digital_output_function_mux_bench.sv
// Purpose: Self-checking bench for the digital output mux
// Assumes: Parameter bus strobes are single-cycle pulses
// Notes:   Relay model sits on the output pins
`timescale 1ns/1ps
module digital_output_function_mux_bench;
	logic               clk = 1'b0;
	logic               nrst = 1'b0;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic               ld = 1'b0;
	logic [15:0]        idx = 16'h0000;
	logic [7:0]         sub = 8'h01;
	logic [31:0]        wd = 32'h0000_0000;
	dom_pkg::dom_status_s st = '0;
	dom_pkg::dom_enc_s  enc = '0;
	dom_pkg::dom_diff_s dif;
	logic [31:0]        rdat;
	logic               ack, p1, p2, p3, oc, ocn, dup, pair_ok;
	logic [2:0]         rly;
	wire  [2:0]         pins = {p1, p2, p3};
	int                 n_fail = 0;
	int                 num_checks = 0;

	// Clock generator
	always #5 clk = ~clk;

	dom_top i_dom_top (.i_clk(clk), .i_nrst(nrst), .i_par_wr(wr),
		.i_par_rd(rd), .i_par_index(idx), .i_par_sub(sub),
		.i_par_wdata(wd), .i_load_defaults(ld), .i_status(st),
		.i_enc(enc), .o_par_rdata(rdat), .o_par_ack(ack),
		.o_first_digital_output(p1), .o_second_digital_output(p2),
		.o_third_digital_output(p3), .o_enc_diff(dif),
		.o_index_open_collector_out(oc),
		.o_index_open_collector_out_oe_n(ocn),
		.o_duplicate_assignment_error(dup));
	dom_relay_model i_dom_relay_model (.i_pins(pins), .i_diff(dif),
		.o_relay_on(rly), .o_pair_ok(pair_ok));

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One bus access, write when w is high
	task acc(input logic w, input logic [15:0] i, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		idx <= i;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		chk("ack", ack, 1);
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task t_regs;
		for (int i = 0; i < 3; i++)
		begin
			acc(0, dom_pkg::IDX_OUT1_SEL + 16'(i), 0);
			chk("sel reset", rdat, 0);
		end
		acc(1, dom_pkg::IDX_OUT1_SEL, 32'h0000_00FF);
		acc(0, dom_pkg::IDX_OUT1_SEL, 0);
		chk("sel max", rdat, 32'h0000_00FF);
		acc(0, 16'h2413, 0);
		chk("unmapped", rdat, 0);
		acc(1, dom_pkg::IDX_OUT1_SEL, 0);
	endtask

	task t_master;
		for (int v = 0; v < 8; v++)
		begin
			acc(1, dom_pkg::IDX_MASTER_DO, 32'(v) << 16);
			tick(1);
			chk("master", pins, {v[0], v[1], v[2]});
		end
		// Another sub-index of the object must not move the pins
		@(posedge clk);
		sub <= 8'h02;
		acc(1, dom_pkg::IDX_MASTER_DO, 32'h0000_0000);
		@(posedge clk);
		sub <= 8'h01;
		tick(1);
		chk("sub refused", pins, 3'b111);
		acc(0, dom_pkg::IDX_MASTER_DO, 0);
		chk("master read", rdat, 32'h0007_0000);
	endtask

	task t_codes;
		logic [6:0] c [14] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
			7'h06, 7'h07, 7'h08, 7'h0B, 7'h0D, 7'h0F, 7'h12, 7'h14, 7'h22};
		for (int k = 0; k < 14; k++)
			for (int n = 0; n < 2; n++)
			begin
				@(posedge clk);
				st <= '0;
				for (int j = 0; j < 3; j++)
					acc(1, dom_pkg::IDX_OUT1_SEL + 16'(j), {n[0], c[k]});
				tick(1);
				chk("idle", pins, {3{!n[0]}});
				@(posedge clk);
				st <= 14'h0001 << (13 - k);
				tick(1);
				chk("active", pins, {3{n[0]}});
				chk("relay", rly, {3{!n[0]}});
			end
	endtask

	task t_undef;
		acc(1, dom_pkg::IDX_OUT1_SEL, 32'h0000_0009);
		acc(1, dom_pkg::IDX_OUT2_SEL, 32'h0000_0080);
		acc(1, dom_pkg::IDX_OUT3_SEL, 32'h0000_007F);
		@(posedge clk);
		st <= '1;
		tick(2);
		chk("undefined", pins, 3'b101);
	endtask

	task t_dflt;
		logic [7:0] e [3] = '{8'h02, 8'h01, 8'h03};
		@(posedge clk);
		st <= '0;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			acc(0, dom_pkg::IDX_OUT1_SEL + 16'(i), 0);
			chk("default", rdat, {24'h00_0000, e[i]});
		end
		chk("dflt pins", pins, 3'b111);
		chk("no dup", dup, 0);
		acc(1, dom_pkg::IDX_OUT2_SEL, 32'h0000_0082);
		tick(1);
		chk("dup", dup, 1);
		acc(1, dom_pkg::IDX_OUT2_SEL, 32'h0000_0001);
		tick(1);
		chk("dup gone", dup, 0);
	endtask

	task t_enc;
		for (int v = 0; v < 8; v++)
		begin
			@(posedge clk);
			enc <= 3'(v);
			tick(1);
			chk("pairs", dif, {v[2], !v[2], v[1], !v[1], v[0], !v[0]});
			chk("oc", {pair_ok, oc, ocn}, {2'b10, !v[0]});
		end
	endtask

	// Reset in mid-run clears selectors and master bits
	task t_rst;
		@(posedge clk);
		nrst <= 1'b0;
		tick(2);
		chk("rst pins", pins, 3'b111);
		@(posedge clk);
		nrst <= 1'b1;
		tick(3);
		chk("rst master", pins, 3'b000);
		acc(0, dom_pkg::IDX_OUT3_SEL, 0);
		chk("rst sel", rdat, 0);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	// ==========================================================
	initial
	begin
		tick(6);
		chk("reset pins", pins, 3'b111);
		@(posedge clk);
		nrst <= 1'b1;
		tick(2);
		t_regs;
		t_master;
		t_codes;
		t_undef;
		t_dflt;
		t_enc;
		t_rst;
		summarize;
	end

	// Cuts a hang short
	initial
	begin
		#100_000;
		n_fail++;
		summarize;
	end
endmodule

// ### test/dom_monitor.sv
// Purpose: Port-level checker for the digital output mux
// Assumes: Selectors and master bits are tracked from bus writes
// Notes:   Checks start one cycle after the synced reset lifts
`timescale 1ns/1ps
module dom_monitor
(
	input wire logic                 i_clk,
	input wire logic                 i_nrst,
	input wire logic                 i_par_wr,
	input wire logic                 i_par_rd,
	input wire logic [15:0]          i_par_index,
	input wire logic [7:0]           i_par_sub,
	input wire logic [31:0]          i_par_wdata,
	input wire logic                 i_load_defaults,
	input wire dom_pkg::dom_status_s i_status,
	input wire dom_pkg::dom_enc_s    i_enc,
	input wire logic [31:0]          o_par_rdata,
	input wire logic                 o_par_ack,
	input wire logic                 o_first_digital_output,
	input wire logic                 o_second_digital_output,
	input wire logic                 o_third_digital_output,
	input wire dom_pkg::dom_diff_s   o_enc_diff,
	input wire logic                 o_index_open_collector_out,
	input wire logic                 o_index_open_collector_out_oe_n,
	input wire logic                 o_duplicate_assignment_error
);
	// ==========================================================
	// Shadow state
	// ==========================================================
	logic [2:0] sy;   // Reset release tracker
	logic [7:0] s1;   // Shadow selectors
	logic [7:0] s2;
	logic [7:0] s3;
	logic [2:0] mst;  // Shadow master bits

	// Lags the design's own synchroniser by one stage
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			sy <= 3'h0;
		else
			sy <= {sy[1:0], 1'b1};

	// Mirrors selector and master writes
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			{s1, s2, s3, mst} <= 27'h000_0000;
		else if (i_load_defaults)
			{s1, s2, s3} <= 24'h02_0103;
		else if (i_par_wr && i_par_index == dom_pkg::IDX_OUT1_SEL)
			s1 <= i_par_wdata[7:0];
		else if (i_par_wr && i_par_index == dom_pkg::IDX_OUT2_SEL)
			s2 <= i_par_wdata[7:0];
		else if (i_par_wr && i_par_index == dom_pkg::IDX_OUT3_SEL)
			s3 <= i_par_wdata[7:0];
		else if (i_par_wr && i_par_index == dom_pkg::IDX_MASTER_DO
			&& i_par_sub == dom_pkg::SUB_MASTER_DO)
			mst <= i_par_wdata[18:16];

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!sy[2]);

	// ==========================================================
	// Assertions
	// ==========================================================
	chk_ack_pulse: assert property ((i_par_wr || i_par_rd) |=> o_par_ack)
		else $error("ack missing");
	chk_ack_quiet: assert property (!(i_par_wr || i_par_rd)
		|=> !o_par_ack) else $error("ack without access");
	chk_sel_read: assert property (i_par_rd && i_par_index == 16'h2410
		|=> o_par_rdata == {24'h00_0000, $past(s1)}) else $error("readback");
	chk_master_pin: assert property (s3 == 8'h00
		|=> o_third_digital_output == $past(mst[2])) else $error("master");
	chk_open_low: assert property (s2 == 8'h01 && i_status.fault_flag
		|=> !o_second_digital_output) else $error("open form");
	chk_closed_high: assert property (s3 == 8'hA2 && i_status.homing_done
		|=> o_third_digital_output) else $error("closed form");
	chk_undef_idle: assert property (s1 == 8'h09
		|=> o_first_digital_output [*2]) else $error("undefined code");
	chk_enc_copy: assert property (1'b1
		|=> o_enc_diff.a_p == $past(i_enc.phase_a)
		&& o_enc_diff.a_n != o_enc_diff.a_p
		&& o_index_open_collector_out_oe_n == !$past(i_enc.phase_z))
		else $error("encoder copy");
	chk_dup_flag: assert property (s1 == 8'h02 && s2[6:0] == 7'h02
		|=> o_duplicate_assignment_error) else $error("duplicate");
	cover property (s1 == 8'h00 && o_first_digital_output);
	cover property (s3 == 8'hA2 && i_status.homing_done);
	cover property (o_duplicate_assignment_error);
	cover property (s2 == 8'h80 && !o_second_digital_output);
endmodule

bind dom_top dom_monitor i_dom_monitor (.*);

// ### test/dom_relay_model.sv
// Purpose: Far-side loads: relay coils and a differential receiver
// Assumes: Coils sink through the output when it is low
// Notes:   Purely combinational
`timescale 1ns/1ps
module dom_relay_model
(
	input  wire logic [2:0]         i_pins,     // Output pin levels
	input  wire dom_pkg::dom_diff_s i_diff,     // Encoder pairs
	output logic [2:0]              o_relay_on, // Coil energised
	output logic                    o_pair_ok   // All pairs valid
);
	// Coil pulls in while the pin sinks current
	assign o_relay_on = ~i_pins;
	// Receiver sees a valid pair only with inverted legs
	assign o_pair_ok = (i_diff.a_p ^ i_diff.a_n)
		& (i_diff.b_p ^ i_diff.b_n) & (i_diff.z_p ^ i_diff.z_n);
endmodule
